// *** shared/clock_path_pkg.sv ***
// Purpose: constants, field layouts and carrier types of the clock path control block
// Assumes: APB data 32 bits, registers 8 bits wide in the low byte lane, except the status word, which reaches bit 10
// Notes:   printed offsets are register indices; the byte address is four times the index
package clock_path_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 10;
  localparam int unsigned REG_W  = 8;

  // register indices (byte address = index * 4)
  localparam logic [IDX_W-1:0] IDX_LOOP_CTRL  = 10'h010;
  localparam logic [IDX_W-1:0] IDX_PREDIV     = 10'h1E0;
  localparam logic [IDX_W-1:0] IDX_SRC_SELECT = 10'h1E1;
  localparam logic [IDX_W-1:0] IDX_COMMIT     = 10'h232;
  localparam logic [IDX_W-1:0] IDX_PATH_STAT  = 10'h233;

  // field positions
  localparam int unsigned LOOP_PWR_LSB   = 0;
  localparam int unsigned LOOP_POL_BIT   = 7;
  localparam int unsigned PREDIV_LSB     = 0;
  localparam int unsigned SRC_BYPASS_BIT = 0;
  localparam int unsigned SRC_OSC_BIT    = 1;

  // path status register bit positions
  localparam int unsigned STAT_PWR_LSB     = 0;
  localparam int unsigned STAT_PENDING_BIT = 2;
  localparam int unsigned STAT_RUN_BIT     = 3;
  localparam int unsigned STAT_OSC_ON_BIT  = 4;
  localparam int unsigned STAT_BYPASS_BIT  = 5;
  localparam int unsigned STAT_OSC_SEL_BIT = 6;
  localparam int unsigned STAT_CLAMP_BIT   = 7;
  localparam int unsigned STAT_RATIO_LSB   = 8;

  // field encodings
  localparam logic [1:0] PWR_NORMAL   = 2'h0;
  localparam logic [1:0] PWR_ASYNC_PD = 2'h1;
  localparam logic [7:0] COMMIT_KEY   = 8'h01;

  // pre-divider: code 0 means divide by two, largest legal code divides by six
  localparam logic [2:0] RATIO_BASE     = 3'h2;
  localparam logic [2:0] RATIO_MAX_CODE = 3'h4;
  localparam logic [2:0] RATIO_MAX      = 3'h6;

  // reset values
  localparam logic [1:0] PWR_RST    = PWR_ASYNC_PD;
  localparam logic       POL_RST    = 1'b0;
  localparam logic [2:0] RATIO_RST  = 3'h2;
  localparam logic       BYPASS_RST = 1'b0;
  localparam logic       OSC_RST    = 1'b0;

  // one set of configuration fields, shadow or active
  typedef struct packed {
    logic [1:0] pwr;
    logic       pol_neg;
    logic [2:0] ratio_code;
    logic       bypass;
    logic       osc_sel;
  } cfg_s;

  // controls handed to the analog clock path
  typedef struct packed {
    logic       loop_run;
    logic       loop_pd;
    logic       pol_neg;
    logic       osc_power;
    logic       ext_to_prescaler;
    logic       bypass;
    logic       osc_sel;
    logic [2:0] ratio;
    logic       ratio_clamped;
  } path_ctrl_s;

  localparam cfg_s CFG_RST = '{pwr: PWR_RST, pol_neg: POL_RST, ratio_code: RATIO_RST,
                               bypass: BYPASS_RST, osc_sel: OSC_RST};

  localparam path_ctrl_s PATH_RST = '{loop_run: 1'b0, loop_pd: 1'b1, pol_neg: POL_RST,
                                      osc_power: OSC_RST, ext_to_prescaler: 1'b0,
                                      bypass: BYPASS_RST, osc_sel: OSC_RST,
                                      ratio: 3'(RATIO_RST + RATIO_BASE),
                                      ratio_clamped: 1'b0};

endpackage : clock_path_pkg

// *** verif/clock_path_config_control_chk.sv ***
// Purpose: port-level assertions for the clock path control block
// Assumes: single pclk domain, presetn asynchronous active low
// Notes:   shadow contents are invisible here; the bench compares them
`timescale 1ns/1ps

module clock_path_config_control_chk
  import clock_path_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire path_ctrl_s        path_ctrl
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic commit_seen;

  // access phase still waiting for its answer
  sequence wait_s;
    psel && penable && !pready;
  endsequence
  // completing write of the key to the commit register
  sequence commit_s;
    psel && penable && pready && pwrite && (paddr == {IDX_COMMIT, 2'b00})
      && (pwdata[7:0] == COMMIT_KEY);
  endsequence

  // registered so that a path_ctrl change can be traced to the edge before it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      commit_seen <= 1'b0;
    end else begin
      commit_seen <= psel && penable && pready && pwrite && (paddr == {IDX_COMMIT, 2'b00})
                     && (pwdata[7:0] == COMMIT_KEY);
    end
  end

  one_wait_a: assert property (wait_s |=> pready)
    else $error("answer not one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property ($rose(pready) |-> $past(penable))
    else $error("pready without access phase");
  idle_quiet_a: assert property (!pready |-> (prdata == '0) && !pslverr)
    else $error("read data or error outside answer");
  commit_ok_a: assert property (commit_s |-> !pslverr)
    else $error("commit write refused");
  ctrl_hold_a: assert property (!$stable(path_ctrl) |-> commit_seen)
    else $error("path control moved without commit");
  run_pd_a: assert property (path_ctrl.loop_run != path_ctrl.loop_pd)
    else $error("loop run and power-down agree");
  ext_feed_a: assert property (path_ctrl.ext_to_prescaler ==
      (path_ctrl.loop_run && !path_ctrl.osc_sel))
    else $error("prescaler feed wrong");
  osc_pwr_a: assert property (path_ctrl.osc_power == path_ctrl.osc_sel)
    else $error("oscillator power wrong");
  ratio_range_a: assert property ((path_ctrl.ratio >= 3'h2) && (path_ctrl.ratio <= 3'h6))
    else $error("ratio out of range");
  clamp_six_a: assert property (path_ctrl.ratio_clamped |-> path_ctrl.ratio == RATIO_MAX)
    else $error("clamped ratio not six");
endmodule : clock_path_config_control_chk

bind clock_path_config_control clock_path_config_control_chk chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .path_ctrl(path_ctrl)
);

// *** verif/tb.sv ***
// Purpose: self-checking bench for the clock path control block over APB
// Assumes: one wait state per transfer, commit lands on the completing edge
// Notes:   expected path controls are rebuilt here from the field values
`timescale 1ns/1ps

module tb
  import clock_path_pkg::*;
;
  localparam logic [ADDR_W-1:0] A_LOOP = {IDX_LOOP_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_PDIV = {IDX_PREDIV, 2'b00};
  localparam logic [ADDR_W-1:0] A_SRC  = {IDX_SRC_SELECT, 2'b00};
  localparam logic [ADDR_W-1:0] A_CMT  = {IDX_COMMIT, 2'b00};
  localparam logic [ADDR_W-1:0] A_STAT = {IDX_PATH_STAT, 2'b00};
  localparam logic [ADDR_W-1:0] A_ODD  = {IDX_LOOP_CTRL, 2'b01};

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  path_ctrl_s        path_ctrl;
  logic [DATA_W-1:0] rd;
  logic              err;
  logic [2:0]        c;
  int                num_errors;
  int                compares;

  clock_path_config_control uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .path_ctrl(path_ctrl)
  );

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic results();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        break;
      end
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      num_errors++;
      $display("[FAIL] %0t no answer", $time);
      results();
    end
  endtask : apb

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
    check({31'h0, err}, 32'h00000000);
  endtask : rchk

  // writes the three shadow registers; upper data bits must be ignored
  task automatic cfg(input logic [1:0] pw, input logic pol, input logic [2:0] cd,
                     input logic byp, input logic osc);
    apb(1'b1, A_LOOP, {24'hFFFFFF, pol, 5'h00, pw});
    apb(1'b1, A_PDIV, {29'h00000000, cd});
    apb(1'b1, A_SRC, {30'h00000000, osc, byp});
  endtask : cfg

  function automatic logic [DATA_W-1:0] ctl(input logic [1:0] pw, input logic pol,
                                             input logic [2:0] cd, input logic byp,
                                             input logic osc);
    path_ctrl_s e;
    e.loop_run = (pw == 2'h0);
    e.loop_pd = (pw != 2'h0);
    e.pol_neg = pol;
    e.osc_power = osc;
    e.ext_to_prescaler = (pw == 2'h0) && !osc;
    e.bypass = byp;
    e.osc_sel = osc;
    e.ratio_clamped = (cd > 3'h4);
    e.ratio = e.ratio_clamped ? 3'h6 : 3'(cd + 3'h2);
    return DATA_W'(e);
  endfunction : ctl

  // main sequence
  initial begin
    num_errors = 0;
    compares = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk(A_LOOP, 32'h00000001);
    rchk(A_PDIV, 32'h00000002);
    rchk(A_SRC, 32'h00000000);
    check(DATA_W'(path_ctrl), ctl(2'h1, 1'b0, 3'h2, 1'b0, 1'b0));
    $display("test defaults done");
    cfg(2'h0, 1'b1, 3'h0, 1'b1, 1'b0);
    rchk(A_LOOP, 32'h00000080);
    // status still shows the reset setup, with the pending flag up
    rchk(A_STAT, 32'h00000405);
    apb(1'b1, A_CMT, 32'h00000002);
    #1 check(DATA_W'(path_ctrl), ctl(2'h1, 1'b0, 3'h2, 1'b0, 1'b0));
    apb(1'b1, A_CMT, 32'h00000001);
    #1 check(DATA_W'(path_ctrl), ctl(2'h0, 1'b1, 3'h0, 1'b1, 1'b0));
    rchk(A_STAT, 32'h00000228);
    $display("test commit done");
    // every ratio code, all four power codes, both sources
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      cfg({c[2], c[0]}, c[1] ^ c[0], c, c[1], c[2]);
      apb(1'b1, A_CMT, 32'h00000001);
      #1 check(DATA_W'(path_ctrl), ctl({c[2], c[0]}, c[1] ^ c[0], c, c[1], c[2]));
    end
    $display("test ratio table done");
    apb(1'b0, 12'h004, 32'h00000000);
    check({31'h0, err}, 32'h00000001);
    check(rd, 32'h00000000);
    // unaligned write is refused and leaves the shadow as it was
    apb(1'b1, A_ODD, 32'h00000000);
    check({31'h0, err}, 32'h00000001);
    rchk(A_LOOP, 32'h00000003);
    $display("test unmapped done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1 check(DATA_W'(path_ctrl), ctl(2'h1, 1'b0, 3'h2, 1'b0, 1'b0));
    rchk(A_PDIV, 32'h00000002);
    rchk(A_SRC, 32'h00000000);
    $display("test second reset done");
    results();
  end
endmodule : tb

// *** verilog/clock_path_config_control.sv ***
// Purpose: APB register block steering the clock source, pre-divider and loop power
// Assumes: single clock pclk at 40 MHz, asynchronous active-low presetn
// Notes:   written values wait in shadow storage until the key 0x01 is written to the commit register
//
// Overview of operation
// - loop power field 01 holds the loop in asynchronous power-down; default value.
// - loop power field 00 runs the loop normally.
// - pre-divider ratio field defaults to 010, dividing by four.
// - default route is clock pin through pre-divider; ratios two to six.
// - path enable bit zero feeds channel dividers from the pre-divider.
// - source select bit zero picks the clock input pin; zero by default.
// - programmed values act only after 0x01 is written to the commit register.
// - the pre-divider never divides by less than two.
// - polarity bit zero means positive, one means negative phase detector polarity.
// - loop on with pin source keeps oscillator off; pin feeds the prescaler.
// - power, ratio, path enable and source bits reset to defaults.
// - path enable one bypasses the pre-divider.
// - source select one picks the on-chip oscillator.
`timescale 1ns/1ps

module clock_path_config_control
  import clock_path_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  output path_ctrl_s             path_ctrl
);

  // all state of the block in one word
  typedef struct packed {
    cfg_s              shadow;
    cfg_s              active;
    path_ctrl_s        path;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } ctrl_state_s;

  localparam ctrl_state_s STATE_RST = '{
    shadow:  CFG_RST,
    active:  CFG_RST,
    path:    PATH_RST,
    pready:  1'b0,
    pslverr: 1'b0,
    prdata:  '0
  };

  ctrl_state_s st_reg;
  ctrl_state_s st_next;

  // ratio of the pending code, ready for the moment it is committed
  logic [2:0] shadow_ratio;
  logic       shadow_clamped;

  prediv_ratio_decode u_shadow_ratio (
    .code    (st_reg.shadow.ratio_code),
    .ratio   (shadow_ratio),
    .clamped (shadow_clamped)
  );

  // address decode: only aligned words land on a register
  logic [IDX_W-1:0] idx;
  logic             aligned;
  logic             hit_loop;
  logic             hit_prediv;
  logic             hit_src;
  logic             hit_commit;
  logic             hit_stat;
  logic             hit_any;

  assign idx        = paddr[ADDR_W-1:2];
  assign aligned    = (paddr[1:0] == 2'h0);
  assign hit_loop   = aligned && (idx == IDX_LOOP_CTRL);
  assign hit_prediv = aligned && (idx == IDX_PREDIV);
  assign hit_src    = aligned && (idx == IDX_SRC_SELECT);
  assign hit_commit = aligned && (idx == IDX_COMMIT);
  assign hit_stat   = aligned && (idx == IDX_PATH_STAT);
  assign hit_any    = hit_loop | hit_prediv | hit_src | hit_commit | hit_stat;

  // read words: config registers echo the shadow copy, the status word
  // shows what the analog path is actually running with
  logic [DATA_W-1:0] rd_loop;
  logic [DATA_W-1:0] rd_prediv;
  logic [DATA_W-1:0] rd_src;
  logic [DATA_W-1:0] rd_stat;
  logic              pending;

  // pending is high while written values still wait for a commit
  assign pending = (st_reg.shadow != st_reg.active);

  always_comb begin
    rd_loop   = '0;
    rd_prediv = '0;
    rd_src    = '0;
    rd_stat   = '0;
    rd_loop[LOOP_PWR_LSB +: 2]          = st_reg.shadow.pwr;
    rd_loop[LOOP_POL_BIT]               = st_reg.shadow.pol_neg;
    rd_prediv[PREDIV_LSB +: 3]          = st_reg.shadow.ratio_code;
    rd_src[SRC_BYPASS_BIT]              = st_reg.shadow.bypass;
    rd_src[SRC_OSC_BIT]                 = st_reg.shadow.osc_sel;
    rd_stat[STAT_PWR_LSB +: 2]          = st_reg.active.pwr;
    rd_stat[STAT_PENDING_BIT]           = pending;
    rd_stat[STAT_RUN_BIT]               = st_reg.path.loop_run;
    rd_stat[STAT_OSC_ON_BIT]            = st_reg.path.osc_power;
    rd_stat[STAT_BYPASS_BIT]            = st_reg.path.bypass;
    rd_stat[STAT_OSC_SEL_BIT]           = st_reg.path.osc_sel;
    rd_stat[STAT_CLAMP_BIT]             = st_reg.path.ratio_clamped;
    rd_stat[STAT_RATIO_LSB +: 3]        = st_reg.path.ratio;
  end

  // next-state logic: APB handshake, shadow writes, commit and path decode
  always_comb begin
    logic             access;
    logic             finish;
    logic             commit;
    logic [REG_W-1:0] wbyte;
    logic [DATA_W-1:0] rd_word;
    cfg_s             new_active;

    access     = psel && penable;
    finish     = access && st_reg.pready;
    wbyte      = pwdata[REG_W-1:0];
    commit     = finish && pwrite && hit_commit && (wbyte == COMMIT_KEY);
    new_active = st_reg.shadow;
    rd_word    = '0;
    st_next    = st_reg;

    // read mux; commit register reads back zero since it acts only on write
    unique case (1'b1)
      hit_loop:   rd_word = rd_loop;
      hit_prediv: rd_word = rd_prediv;
      hit_src:    rd_word = rd_src;
      hit_stat:   rd_word = rd_stat;
      default:    rd_word = '0;
    endcase

    // first access cycle: prepare the answer, one wait state keeps every
    // bus output straight from a flip-flop
    if (access && !st_reg.pready) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = !hit_any;
      st_next.prdata  = pwrite ? '0 : rd_word;
    end

    // completing edge: the write lands here and nowhere else
    if (finish) begin
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.prdata  = '0;
      if (pwrite) begin
        // software writes touch only the shadow copy
        if (hit_loop) begin
          st_next.shadow.pwr     = wbyte[LOOP_PWR_LSB +: 2];
          st_next.shadow.pol_neg = wbyte[LOOP_POL_BIT];
        end
        if (hit_prediv) begin
          st_next.shadow.ratio_code = wbyte[PREDIV_LSB +: 3];
        end
        if (hit_src) begin
          st_next.shadow.bypass  = wbyte[SRC_BYPASS_BIT];
          st_next.shadow.osc_sel = wbyte[SRC_OSC_BIT];
        end
      end
    end

    // commit copies the pending values into the active set in the
    // same edge that accepts the write; other values on the commit
    // register are ignored so a stray write cannot half-apply a setup
    if (commit) begin
      st_next.active = new_active;
      // loop power: only 00 runs, 01 and the undefined codes power down
      st_next.path.loop_run = (new_active.pwr == PWR_NORMAL);
      st_next.path.loop_pd  = (new_active.pwr != PWR_NORMAL);
      st_next.path.pol_neg  = new_active.pol_neg;
      // source select: zero takes the pin, one the on-chip oscillator
      st_next.path.osc_sel   = new_active.osc_sel;
      st_next.path.osc_power = new_active.osc_sel;
      // with the loop on and the pin selected the oscillator stays dark
      // and the external clock drives the prescaler directly
      st_next.path.ext_to_prescaler =
        (new_active.pwr == PWR_NORMAL) && !new_active.osc_sel;
      // path enable: zero routes through the pre-divider, one bypasses it
      st_next.path.bypass        = new_active.bypass;
      st_next.path.ratio         = shadow_ratio;
      st_next.path.ratio_clamped = shadow_clamped;
    end
  end

  // the single state register; reset restores all defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs come straight from the state register; after reset the path
  // shows pin source, pre-divider by four and loop powered down
  assign prdata    = st_reg.prdata;
  assign pready    = st_reg.pready;
  assign pslverr   = st_reg.pslverr;
  assign path_ctrl = st_reg.path;

endmodule : clock_path_config_control

// *** verilog/prediv_ratio_decode.sv ***
// Purpose: turn a pre-divider code into the division ratio it applies
// Assumes: codes above the largest legal one can be written by software
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/1ps

module prediv_ratio_decode
  import clock_path_pkg::*;
(
  input  wire logic [2:0] code,
  output logic      [2:0] ratio,
  output logic            clamped
);

  // undefined codes fall back to the slowest ratio so the channel
  // dividers never see a faster clock than any legal setting gives
  always_comb begin
    clamped = (code > RATIO_MAX_CODE);
    if (clamped) begin
      ratio = RATIO_MAX;
    end else begin
      ratio = 3'(code + RATIO_BASE); // least division is two
    end
  end

endmodule : prediv_ratio_decode
